// ===== rtl/mci_cfg.svh
// Frame layout, status codes and reset values of the command frame interpreter
`ifndef MCI_CFG_SVH
`define MCI_CFG_SVH

// ----------------------------------------------------------------
// Frame positions (byte-serial numbering, CAN frames start at 1)
// ----------------------------------------------------------------
`define MCI_POS_ADDR 4'h0
`define MCI_POS_OP 4'h1
`define MCI_POS_TYPE 4'h2
`define MCI_POS_BANK 4'h3
`define MCI_POS_V3 4'h4
`define MCI_POS_V2 4'h5
`define MCI_POS_V1 4'h6
`define MCI_POS_V0 4'h7
`define MCI_POS_CHK 4'h8

// ----------------------------------------------------------------
// Reply positions
// ----------------------------------------------------------------
`define MCI_RPOS_RADDR 4'h0
`define MCI_RPOS_MADDR 4'h1
`define MCI_RPOS_STATUS 4'h2
`define MCI_RPOS_OP 4'h3
`define MCI_RPOS_CHK 4'h8

// ----------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------
`define MCI_ST_OK 8'h64
`define MCI_ST_LOADED 8'h65
`define MCI_ST_BAD_SUM 8'h01
`define MCI_ST_BAD_OP 8'h02
`define MCI_ST_BAD_TYPE 8'h03
`define MCI_ST_BAD_VALUE 8'h04
`define MCI_ST_LOCKED 8'h05
`define MCI_ST_NOT_AVAIL 8'h06

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MCI_BYTE_RST 8'h00
`define MCI_WORD_RST 32'h0000_0000

`endif

// ===== rtl/mci_fifo.sv
// Receive byte FIFO with registered input ready
`timescale 1ns/1ps

module mci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  mci_stream_if.src out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic push, pop;

  assign push = in_valid && ready_reg;
  assign pop = out.valid && out.ready;
  assign out.valid = (cnt_reg != '0);
  assign out.data = mem_reg[rd_ptr_reg];
  assign in_ready = ready_reg;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    ready_next = (cnt_next != CW'(DEPTH));
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule

// ===== rtl/mci_frame_interp.sv
// Command frame interpreter: receive, check, execute or store, reply
//
// Overview of operation
// - Payload: opcode, type, bank, four-byte value
// - Serial frames add address and checksum bytes
// - Byte order address..value MSB first, checksum
// - Request checksum is 8-bit sum of eight
// - Reply: addresses, status, opcode, value, checksum
// - Reply checksum sums all other reply bytes
// - Never transmit unless answering a command
// - Reply only after command processing completes
// - CAN request: payload only, ID is address
// - CAN reply: no reply address/checksum, ID carries reply
// - Status 100 done, 101 stored
// - Status 1 checksum, 2 opcode, 3 type, 4 value
// - Status 5 locked, 6 not available
// - Store sequences and run them without host
`timescale 1ns/1ps
`include "mci_cfg.svh"

module mci_frame_interp #(
  parameter int FIFO_DEPTH = 4,
  parameter int PROG_DEPTH = 64
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic can_mode,
  input wire mci_pkg::mci_byte_t module_addr,
  input wire mci_pkg::mci_byte_t reply_addr,
  input wire mci_pkg::mci_byte_t rx_can_id,
  input wire mci_pkg::mci_byte_t rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output mci_pkg::mci_byte_t tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_last,
  output logic tx_drive,
  output mci_pkg::mci_byte_t tx_can_id,
  output logic cmd_valid,
  output logic cmd_standalone,
  output mci_pkg::mci_byte_t cmd_op,
  output mci_pkg::mci_byte_t cmd_type,
  output mci_pkg::mci_byte_t cmd_bank,
  output mci_pkg::mci_word_t cmd_value,
  input wire logic exec_done,
  input wire mci_pkg::mci_byte_t exec_status,
  input wire mci_pkg::mci_word_t exec_value,
  input wire logic prog_load,
  input wire logic prog_clear,
  input wire logic prog_run,
  output logic prog_busy
);
  import mci_pkg::*;
  localparam int PAW = $clog2(PROG_DEPTH);
  localparam int PCW = $clog2(PROG_DEPTH + 1);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mci_state_t state_reg, state_next;
  logic [3:0] pos_reg, pos_next;
  logic [3:0] tidx_reg, tidx_next;
  mci_byte_t addr_reg, addr_next;
  mci_byte_t op_reg, op_next;
  mci_byte_t typ_reg, typ_next;
  mci_byte_t bank_reg, bank_next;
  mci_word_t val_reg, val_next;
  mci_byte_t chk_reg, chk_next;
  mci_byte_t sum_reg, sum_next;
  mci_byte_t tsum_reg, tsum_next;
  mci_byte_t status_reg, status_next;
  mci_byte_t tx_data_reg, tx_data_next;
  mci_byte_t tx_id_reg, tx_id_next;
  logic tx_valid_reg, tx_valid_next;
  logic tx_last_reg, tx_last_next;
  logic tx_drive_reg, tx_drive_next;
  logic cmd_valid_reg, cmd_valid_next;
  logic standalone_reg, standalone_next;
  logic frame_can_reg, frame_can_next;
  logic [PAW-1:0] run_idx_reg, run_idx_next;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  mci_stream_if #(.W(8)) rx_s ();
  mci_cmd_if prog_wr ();
  mci_cmd_if prog_rd ();
  logic [PCW-1:0] prog_count;
  logic prog_full, prog_wr_en, prog_rd_en;
  logic [3:0] p, t_first;
  mci_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out(rx_s.src)
  );
  mci_prog_store #(.DEPTH(PROG_DEPTH)) u_prog (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clear(prog_clear),
    .wr(prog_wr.dst),
    .rd_en(prog_rd_en),
    .rd_addr(run_idx_reg),
    .rd(prog_rd.src),
    .count(prog_count),
    .full(prog_full)
  );

  // Parser stalls outside reception, so the FIFO fills and backs up the host
  assign rx_s.ready = (state_reg == MCI_S_RX);
  assign prog_wr.valid = prog_wr_en;
  assign prog_wr.op = op_reg;
  assign prog_wr.typ = typ_reg;
  assign prog_wr.bank = bank_reg;
  assign prog_wr.value = val_reg;
  assign prog_rd_en = (state_reg == MCI_S_FETCH);
  // CAN frames carry no address byte, numbering starts at the opcode
  assign p = (pos_reg == `MCI_POS_ADDR && can_mode) ? `MCI_POS_OP : pos_reg;
  assign t_first = frame_can_reg ? `MCI_RPOS_MADDR : `MCI_RPOS_RADDR;
  // ----------------------------------------------------------------
  // Reply byte selection
  // ----------------------------------------------------------------
  function automatic mci_byte_t rep_byte(input logic [3:0] i, input mci_byte_t s);
    case (i)
      `MCI_RPOS_RADDR: rep_byte = reply_addr;
      `MCI_RPOS_MADDR: rep_byte = module_addr;
      `MCI_RPOS_STATUS: rep_byte = status_reg;
      `MCI_RPOS_OP: rep_byte = op_reg;
      `MCI_POS_V3: rep_byte = val_reg[31:24];
      `MCI_POS_V2: rep_byte = val_reg[23:16];
      `MCI_POS_V1: rep_byte = val_reg[15:8];
      `MCI_POS_V0: rep_byte = val_reg[7:0];
      `MCI_RPOS_CHK: rep_byte = s;
      default: rep_byte = `MCI_BYTE_RST;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pos_next = pos_reg;
    tidx_next = tidx_reg;
    addr_next = addr_reg;
    op_next = op_reg;
    typ_next = typ_reg;
    bank_next = bank_reg;
    val_next = val_reg;
    chk_next = chk_reg;
    sum_next = sum_reg;
    tsum_next = tsum_reg;
    status_next = status_reg;
    tx_data_next = tx_data_reg;
    tx_id_next = tx_id_reg;
    tx_valid_next = tx_valid_reg;
    tx_last_next = tx_last_reg;
    tx_drive_next = tx_drive_reg;
    cmd_valid_next = 1'b0;
    standalone_next = standalone_reg;
    frame_can_next = frame_can_reg;
    run_idx_next = run_idx_reg;
    prog_wr_en = 1'b0;
    case (state_reg)
      MCI_S_RX: begin
        if (rx_s.valid) begin
          case (p)
            `MCI_POS_ADDR: addr_next = rx_s.data;
            `MCI_POS_OP: op_next = rx_s.data;
            `MCI_POS_TYPE: typ_next = rx_s.data;
            `MCI_POS_BANK: bank_next = rx_s.data;
            `MCI_POS_V3: val_next[31:24] = rx_s.data;
            `MCI_POS_V2: val_next[23:16] = rx_s.data;
            `MCI_POS_V1: val_next[15:8] = rx_s.data;
            `MCI_POS_V0: val_next[7:0] = rx_s.data;
            default: chk_next = rx_s.data;
          endcase
          if (pos_reg == `MCI_POS_ADDR) begin
            frame_can_next = can_mode;
            sum_next = rx_s.data;
            if (can_mode) begin
              addr_next = rx_can_id;
            end
          end else if (p != `MCI_POS_CHK) begin
            sum_next = sum_reg + rx_s.data;
          end
          if ((can_mode || frame_can_reg) ? (p == `MCI_POS_V0) : (p == `MCI_POS_CHK)) begin
            pos_next = `MCI_POS_ADDR;
            state_next = MCI_S_CHECK;
          end else begin
            pos_next = p + 4'h1;
          end
        end else if (pos_reg == `MCI_POS_ADDR && prog_run && prog_count != '0) begin
          run_idx_next = '0;
          standalone_next = 1'b1;
          state_next = MCI_S_FETCH;
        end
      end
      MCI_S_CHECK: begin
        if (addr_reg != module_addr) begin
          state_next = MCI_S_RX;
        end else if (!frame_can_reg && chk_reg != sum_reg) begin
          status_next = `MCI_ST_BAD_SUM;
          state_next = MCI_S_TX;
        end else if (prog_load) begin
          prog_wr_en = !prog_full;
          status_next = prog_full ? `MCI_ST_BAD_VALUE : `MCI_ST_LOADED;
          state_next = MCI_S_TX;
        end else begin
          cmd_valid_next = 1'b1;
          standalone_next = 1'b0;
          state_next = MCI_S_EXEC;
        end
      end
      MCI_S_EXEC: begin
        if (exec_done) begin
          status_next = exec_status;
          val_next = exec_value;
          state_next = MCI_S_TX;
        end
      end
      MCI_S_TX: begin
        if (!tx_valid_reg) begin
          tidx_next = t_first;
          tsum_next = `MCI_BYTE_RST;
          tx_data_next = rep_byte(t_first, `MCI_BYTE_RST);
          tx_id_next = reply_addr;
          tx_valid_next = 1'b1;
          tx_drive_next = 1'b1;
          tx_last_next = 1'b0;
        end else if (tx_ready) begin
          if (tx_last_reg) begin
            tx_valid_next = 1'b0;
            tx_drive_next = 1'b0;
            tx_last_next = 1'b0;
            state_next = MCI_S_RX;
          end else begin
            tidx_next = tidx_reg + 4'h1;
            tsum_next = tsum_reg + tx_data_reg;
            tx_data_next = rep_byte(tidx_reg + 4'h1, tsum_reg + tx_data_reg);
            tx_last_next = frame_can_reg ? (tidx_reg + 4'h1 == `MCI_POS_V0)
                                         : (tidx_reg + 4'h1 == `MCI_RPOS_CHK);
          end
        end
      end
      MCI_S_FETCH: state_next = MCI_S_PISSUE;
      MCI_S_PISSUE: begin
        op_next = prog_rd.op;
        typ_next = prog_rd.typ;
        bank_next = prog_rd.bank;
        val_next = prog_rd.value;
        cmd_valid_next = 1'b1;
        state_next = MCI_S_PEXEC;
      end
      MCI_S_PEXEC: begin
        if (exec_done) begin
          if (!prog_run || PCW'(run_idx_reg) + 1'b1 >= prog_count) begin
            standalone_next = 1'b0;
            state_next = MCI_S_RX;
          end else begin
            run_idx_next = run_idx_reg + 1'b1;
            state_next = MCI_S_FETCH;
          end
        end
      end
      default: state_next = MCI_S_RX;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= MCI_S_RX;
      pos_reg <= `MCI_POS_ADDR;
      tidx_reg <= `MCI_RPOS_RADDR;
      addr_reg <= `MCI_BYTE_RST;
      op_reg <= `MCI_BYTE_RST;
      typ_reg <= `MCI_BYTE_RST;
      bank_reg <= `MCI_BYTE_RST;
      val_reg <= `MCI_WORD_RST;
      chk_reg <= `MCI_BYTE_RST;
      sum_reg <= `MCI_BYTE_RST;
      tsum_reg <= `MCI_BYTE_RST;
      status_reg <= `MCI_BYTE_RST;
      tx_data_reg <= `MCI_BYTE_RST;
      tx_id_reg <= `MCI_BYTE_RST;
      tx_valid_reg <= 1'b0;
      tx_last_reg <= 1'b0;
      tx_drive_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      standalone_reg <= 1'b0;
      frame_can_reg <= 1'b0;
      run_idx_reg <= '0;
    end else begin
      state_reg <= state_next;
      pos_reg <= pos_next;
      tidx_reg <= tidx_next;
      addr_reg <= addr_next;
      op_reg <= op_next;
      typ_reg <= typ_next;
      bank_reg <= bank_next;
      val_reg <= val_next;
      chk_reg <= chk_next;
      sum_reg <= sum_next;
      tsum_reg <= tsum_next;
      status_reg <= status_next;
      tx_data_reg <= tx_data_next;
      tx_id_reg <= tx_id_next;
      tx_valid_reg <= tx_valid_next;
      tx_last_reg <= tx_last_next;
      tx_drive_reg <= tx_drive_next;
      cmd_valid_reg <= cmd_valid_next;
      standalone_reg <= standalone_next;
      frame_can_reg <= frame_can_next;
      run_idx_reg <= run_idx_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tx_data = tx_data_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_last = tx_last_reg;
  assign tx_drive = tx_drive_reg;
  assign tx_can_id = tx_id_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_standalone = standalone_reg;
  assign cmd_op = op_reg;
  assign cmd_type = typ_reg;
  assign cmd_bank = bank_reg;
  assign cmd_value = val_reg;
  assign prog_busy = standalone_reg;
endmodule

// ===== rtl/mci_if.sv
// Byte stream and stored command carriers between interpreter modules
`timescale 1ns/1ps

interface mci_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport dst(input valid, input data, output ready);
endinterface

interface mci_cmd_if;
  logic valid;
  logic [7:0] op;
  logic [7:0] typ;
  logic [7:0] bank;
  logic [31:0] value;
  modport src(output valid, output op, output typ, output bank, output value);
  modport dst(input valid, input op, input typ, input bank, input value);
endinterface

// ===== rtl/mci_pkg.sv
// Types shared by the command frame interpreter
package mci_pkg;

  typedef enum logic [2:0] {
    MCI_S_RX = 3'b000,
    MCI_S_CHECK = 3'b001,
    MCI_S_EXEC = 3'b010,
    MCI_S_TX = 3'b011,
    MCI_S_FETCH = 3'b100,
    MCI_S_PISSUE = 3'b101,
    MCI_S_PEXEC = 3'b110
  } mci_state_t;

  typedef logic [7:0] mci_byte_t;
  typedef logic [31:0] mci_word_t;

endpackage

// ===== rtl/mci_prog_store.sv
// Stored-program memory for standalone command sequences
`timescale 1ns/1ps

module mci_prog_store #(
  parameter int DEPTH = 64
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clear,
  mci_cmd_if.dst wr,
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  mci_cmd_if.src rd,
  output logic [$clog2(DEPTH+1)-1:0] count,
  output logic full
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);

  logic [55:0] mem_reg [DEPTH];
  logic [55:0] rd_word_reg;
  logic rd_valid_reg;
  logic [CW-1:0] cnt_reg, cnt_next;

  assign count = cnt_reg;
  assign full = (cnt_reg == CW'(DEPTH));
  assign rd.valid = rd_valid_reg;
  assign rd.op = rd_word_reg[55:48];
  assign rd.typ = rd_word_reg[47:40];
  assign rd.bank = rd_word_reg[39:32];
  assign rd.value = rd_word_reg[31:0];

  always_comb begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = '0;
    end else if (wr.valid && !full) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      rd_valid_reg <= rd_en;
    end
  end

  // Sequences are appended in arrival order
  always_ff @(posedge core_clk) begin
    if (wr.valid && !full && !clear) begin
      mem_reg[cnt_reg[AW-1:0]] <= {wr.op, wr.typ, wr.bank, wr.value};
    end
    if (rd_en) begin
      rd_word_reg <= mem_reg[rd_addr];
    end
  end
endmodule

// ===== verification/mci_frame_interp_props.sv
// Concurrent checks on the interpreter top-level ports
`timescale 1ns/1ps

module mci_frame_interp_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic can_mode,
  input wire logic cmd_valid,
  input wire logic cmd_standalone,
  input wire logic exec_done,
  input wire logic prog_busy,
  input wire mci_pkg::mci_byte_t tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_last,
  input wire logic tx_drive,
  input wire mci_pkg::mci_byte_t tx_can_id
);
  import mci_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Helper state: pending command, reply byte count and running sum
  // ----------------------------------------------------------------
  logic take;
  logic pend_reg, pend_next;
  logic [3:0] cnt_reg, cnt_next;
  mci_byte_t sum_reg, sum_next;

  always_comb begin
    take = tx_valid && tx_ready;
    pend_next = pend_reg;
    if (exec_done) begin
      pend_next = 1'b0;
    end
    if (cmd_valid) begin
      pend_next = 1'b1;
    end
    cnt_next = take ? (tx_last ? 4'h0 : cnt_reg + 4'h1) : cnt_reg;
    sum_next = take ? (tx_last ? 8'h00 : sum_reg + tx_data) : sum_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sum_reg <= 8'h00;
    end else begin
      pend_reg <= pend_next;
      cnt_reg <= cnt_next;
      sum_reg <= sum_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  reply_held_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed before taken");
  drive_covers_a: assert property (tx_valid |-> tx_drive)
    else $error("reply byte without bus drive");
  no_early_reply_a: assert property (pend_reg |-> !tx_valid)
    else $error("reply before command finished");
  quiet_standalone_a: assert property (cmd_standalone |-> !tx_drive)
    else $error("bus driven during standalone run");
  busy_mirror_a: assert property (prog_busy == cmd_standalone)
    else $error("busy flag differs from standalone flag");
  release_bus_a: assert property (take && tx_last |=> !tx_valid && !tx_drive)
    else $error("bus kept after last reply byte");
  single_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse longer than one cycle");
  reply_length_a: assert property (take && tx_last |-> cnt_reg == (can_mode ? 4'h6 : 4'h8))
    else $error("reply length wrong");
  reply_sum_a: assert property (take && tx_last && !can_mode |-> tx_data == sum_reg)
    else $error("reply checksum wrong");
  can_id_held_a: assert property (tx_drive && $past(tx_drive) |-> $stable(tx_can_id))
    else $error("reply identifier changed in reply");

  cover property (take && tx_last && can_mode);
  cover property (cmd_valid && cmd_standalone);
  cover property (tx_valid && !tx_ready);
endmodule

// ===== verification/mci_host_model.sv
// Host bus master model: sends request frames, collects reply bytes
`timescale 1ns/1ps

module mci_host_model (
  input wire logic core_clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [8:0] rq[$];
  bit stall = 1'b0;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    tx_ready = 1'b1;
  end

  // Each byte held until taken, line inverted once released
  task automatic send(input logic [7:0] fr[9], input int n);
    for (int i = 0; i < n; i++) begin
      rx_data <= fr[i];
      rx_valid <= 1'b1;
      do @(posedge core_clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_data <= ~fr[n-1];
  endtask

  // Reply collection with optional random stalls
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) begin
      rq.push_back({tx_last, tx_data});
    end
    tx_ready <= stall ? 1'(($urandom % 3) != 0) : 1'b1;
  end
endmodule

// ===== verification/tb.sv
// Self-checking bench for the command frame interpreter
`timescale 1ns/1ps

module tb;
  import mci_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic can_mode = 1'b0;
  logic prog_load = 1'b0;
  logic prog_clear = 1'b0;
  logic prog_run = 1'b0;
  logic exec_done = 1'b0;
  mci_byte_t module_addr = 8'h21;
  mci_byte_t reply_addr = 8'h02;
  mci_byte_t rx_can_id = 8'h21;
  mci_byte_t exec_status = 8'h00;
  mci_word_t exec_value = 32'h0000_0000;
  mci_byte_t rx_data, tx_data, tx_can_id, cmd_op, cmd_type, cmd_bank, ex_st, last_op, op, nb;
  mci_word_t cmd_value, last_val, v;
  logic rx_valid, rx_ready, tx_valid, tx_ready, tx_last, tx_drive;
  logic cmd_valid, cmd_standalone, prog_busy, ex_busy;
  logic [15:0] last_tb;
  int error_cnt = 0;
  int comparisons = 0;
  int ex_wait, n_cmd, n_sa, nc, t;
  mci_byte_t sts[6] = '{8'h64, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};

  always #50 core_clk = ~core_clk;

  mci_frame_interp #(.PROG_DEPTH(8)) DUT (.core_clk, .rst_b, .can_mode, .module_addr,
    .reply_addr, .rx_can_id, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready,
    .tx_last, .tx_drive, .tx_can_id, .cmd_valid, .cmd_standalone, .cmd_op, .cmd_type,
    .cmd_bank, .cmd_value, .exec_done, .exec_status, .exec_value, .prog_load, .prog_clear,
    .prog_run, .prog_busy);

  mci_host_model host (.core_clk, .rx_ready, .rx_valid, .rx_data, .tx_valid, .tx_data,
    .tx_last, .tx_ready);

  // ----------------------------------------------------------------
  // Executor stand-in: answers each command 1..4 cycles after its pulse is sampled
  // ----------------------------------------------------------------
  initial begin
    ex_busy = 1'b0;
    n_cmd = 0;
    n_sa = 0;
  end
  always @(posedge core_clk) begin
    exec_done <= 1'b0;
    if (cmd_valid === 1'b1) begin
      ex_busy <= 1'b1;
      ex_wait <= $urandom_range(3, 0);
      n_cmd <= n_cmd + 1;
      last_op <= cmd_op;
      last_val <= cmd_value;
      last_tb <= {cmd_type, cmd_bank};
      if (cmd_standalone === 1'b1) begin
        n_sa <= n_sa + 1;
      end
    end else if (ex_busy && ex_wait == 0) begin
      ex_busy <= 1'b0;
      exec_done <= 1'b1;
      exec_status <= ex_st;
      exec_value <= $urandom;
    end else if (ex_busy) begin
      ex_wait <= ex_wait - 1;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic can, input mci_byte_t addr, input logic bad);
    mci_byte_t f[9];
    f = '{addr, op, nb, ~nb, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) f[8] = f[8] + f[i];
    f[8] = f[8] ^ {7'h00, bad};
    if (can) begin
      for (int i = 0; i < 8; i++) f[i] = f[i+1];
    end
    can_mode <= can;
    rx_can_id <= addr;
    host.send(f, can ? 7 : 9);
  endtask

  task automatic check_reply(input logic can, input mci_byte_t st, ref mci_word_t rv);
    mci_byte_t e[9];
    int n;
    n = can ? 7 : 9;
    t = 0;
    while (host.rq.size() < n && t < 300) begin
      @(posedge core_clk);
      t++;
    end
    // Built after the reply, once the executor value stands
    e = '{reply_addr, module_addr, st, op, rv[31:24], rv[23:16], rv[15:8], rv[7:0], 8'h00};
    for (int i = 0; i < 8; i++) e[8] = e[8] + e[i];
    chk("reply length", n, host.rq.size());
    for (int i = 0; i < n && i < host.rq.size(); i++)
      chk("reply byte", {23'h0, i == n - 1, e[i + int'(can)]}, host.rq[i]);
    host.rq.delete();
  endtask

  task automatic close_out;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    error_cnt++;
    close_out;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    t = $urandom(2333);
    ex_st = 8'h64;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    host.stall = 1'b1;
    // Every executor status, random fields, next frame only after reply
    foreach (sts[k]) begin
      ex_st = sts[k];
      op = $urandom;
      nb = $urandom;
      v = $urandom;
      cmd(1'b0, module_addr, 1'b0);
      check_reply(1'b0, sts[k], exec_value);
      chk("command opcode", op, last_op);
      chk("command value", v, last_val);
      chk("command type and bank", {nb, ~nb}, last_tb);
    end
    // Corrupted checksum: error reply, nothing executed
    nc = n_cmd;
    cmd(1'b0, module_addr, 1'b1);
    check_reply(1'b0, 8'h01, v);
    chk("command count on bad sum", nc, n_cmd);
    // Frame for another module: no reply at all
    cmd(1'b0, module_addr + 8'h01, 1'b0);
    repeat (60) @(posedge core_clk);
    chk("reply to foreign frame", 0, host.rq.size());
    // CAN framing both ways
    ex_st = 8'h64;
    cmd(1'b1, module_addr, 1'b0);
    check_reply(1'b1, 8'h64, exec_value);
    chk("reply identifier", reply_addr, tx_can_id);
    can_mode <= 1'b0;
    // Store two commands, then run them without host
    prog_clear <= 1'b1;
    @(posedge core_clk);
    prog_clear <= 1'b0;
    prog_load <= 1'b1;
    nc = n_cmd;
    repeat (2) begin
      op = $urandom;
      cmd(1'b0, module_addr, 1'b0);
      check_reply(1'b0, 8'h65, v);
    end
    chk("command count on load", nc, n_cmd);
    prog_load <= 1'b0;
    prog_run <= 1'b1;
    t = 0;
    while (n_sa < 2 && t < 100) begin
      @(posedge core_clk);
      t++;
    end
    prog_run <= 1'b0;
    repeat (40) @(posedge core_clk);
    chk("standalone commands", 2, n_sa);
    chk("standalone opcode", op, last_op);
    chk("busy after run", 0, prog_busy);
    chk("reply during run", 0, host.rq.size());
    close_out;
  end
endmodule

bind mci_frame_interp mci_frame_interp_props u_props (.core_clk, .rst_b, .can_mode,
  .cmd_valid, .cmd_standalone, .exec_done, .prog_busy, .tx_data, .tx_valid, .tx_ready,
  .tx_last, .tx_drive, .tx_can_id);
